// ---- rtl/internal_clock_source.sv ----
// Clock source selection, dividers and oscillator controls with Avalon-MM registers.
// Assumes the oscillator and reference clocks arrive asynchronously and are
// far slower than clk; stop_req comes from logic on clk.
`timescale 1ns/1ps
module internal_clock_source #(
  parameter int LIM_W = 10
) (
  input  wire logic                                clk,
  input  wire logic                                rstn,
  input  wire logic                                ce,
  input  wire logic [4:0]                          address,
  input  wire logic                                read,
  input  wire logic                                write,
  input  wire logic [31:0]                         writedata,
  input  wire logic [3:0]                          byteenable,
  output logic      [31:0]                         readdata,
  output logic                                     waitrequest,
  input  wire logic                                dco_low_clk,
  input  wire logic                                dco_mid_clk,
  input  wire logic                                int_ref_clk,
  input  wire logic                                ext_clk_pin,
  input  wire logic                                osc_clock_in,
  input  wire logic                                osc_init,
  input  wire logic                                stop_req,
  output logic                                     divided_clock_output,
  output logic                                     bus_clk,
  output logic                                     debug_clk,
  output logic                                     loop_ref_clk,
  output logic                                     loop_enable,
  output logic                                     int_ref_active,
  output logic [clock_source_pkg::TRIM_W-1:0]      int_ref_trim,
  output logic [1:0]                               oscillator_range_select,
  output logic                                     max_freq_32k_option,
  output clock_source_pkg::osc_ctrl_s              osc_ctrl,
  output clock_source_pkg::mode_e                  mode
);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------

  // Half-period limit for a divide factor of two to the power exp2.
  function automatic logic [LIM_W-1:0] ratio_limit(input logic [3:0] exp2);
    logic [10:0] f;
    f = 11'h1 << exp2;
    return LIM_W'(f - 11'h1);
  endfunction

  logic [clock_source_pkg::SYNC_W-1:0] lvl, rise, fall;
  logic [7:0]  ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d;
  logic [clock_source_pkg::TRIM_W-1:0] trim_q, trim_d;
  logic [1:0]  range_q, range_d, src_q, src_d, src_req, sel_src;
  logic        dmx_q, dmx_d, done_q, done_d, req, wr_ok;
  logic [31:0] rdata_q, rdata_d;
  logic        bus_q, bus_d, dbg_q, dbg_d, lref_q, lref_d, len_q, len_d, iract_q, iract_d;
  clock_source_pkg::mode_e mode_q, mode_d;
  logic        ext_rise, ext_fall, loop_rise, loop_fall, src_rise, src_fall, ext_div_out;
  logic        out_wrap, stopped, low_power;
  logic [2:0]  reference_divider_select_eff;
  logic [3:0]  reference_divider_select_exp;

  // ---------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------

  // All asynchronous clocks and the oscillator ready flag pass one filter.
  level_sync #(.W(clock_source_pkg::SYNC_W)) u_sync (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce),
    .din   ({osc_init, osc_clock_in, ext_clk_pin, int_ref_clk, dco_mid_clk, dco_low_clk}),
    .level (lvl),
    .rise  (rise),
    .fall  (fall)
  );

  // ---------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------

  // One wait cycle per access; writes land at the edge after the wait, where waitrequest is low.
  assign req         = read || write;
  assign waitrequest = req && !(done_q && ce);
  assign wr_ok       = write && done_q;

  // Next register values and read data.
  always_comb begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    trim_d  = trim_q;
    range_d = range_q;
    dmx_d   = dmx_q;
    done_d  = req && !done_q;
    rdata_d = rdata_q;
    if (wr_ok) begin
      case (address)
        clock_source_pkg::OFS_CTRL1: begin
          if (byteenable[0]) ctrl1_d = writedata[7:0];
        end
        clock_source_pkg::OFS_CTRL2: begin
          if (byteenable[0]) ctrl2_d = writedata[7:0];
        end
        clock_source_pkg::OFS_TRIM: begin
          if (byteenable[0]) trim_d[7:0] = writedata[7:0];
          if (byteenable[1]) trim_d[8] = writedata[8];
        end
        clock_source_pkg::OFS_STATUS: begin
          if (byteenable[0]) begin
            dmx_d = writedata[clock_source_pkg::ST_DMX];
            // Ranges that are not built are ignored.
            if (writedata[7:6] == clock_source_pkg::RANGE_LOW || writedata[7:6] == clock_source_pkg::RANGE_MID) begin
              range_d = writedata[7:6];
            end
          end
        end
        default: ;
      endcase
    end
    if (read && !done_q) begin
      case (address)
        clock_source_pkg::OFS_CTRL1:  rdata_d = {24'h0, ctrl1_q};
        clock_source_pkg::OFS_CTRL2:  rdata_d = {24'h0, ctrl2_q};
        clock_source_pkg::OFS_TRIM:   rdata_d = {23'h0, trim_q};
        clock_source_pkg::OFS_STATUS: rdata_d = {24'h0, range_q, dmx_q, ctrl1_q[clock_source_pkg::C1_LREF], src_q,
                                                 lvl[clock_source_pkg::S_OSC_INIT], 1'b0};
        clock_source_pkg::OFS_MODE:   rdata_d = {29'h0, mode_q};
        default:                      rdata_d = 32'h0;
      endcase
    end
  end

  // Register file and bus handshake state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl1_q <= clock_source_pkg::CTRL1_RST;
      ctrl2_q <= clock_source_pkg::CTRL2_RST;
      trim_q  <= clock_source_pkg::TRIM_RST;
      range_q <= clock_source_pkg::RANGE_RST;
      dmx_q   <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= 32'h0;
    end else if (ce) begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      trim_q  <= trim_d;
      range_q <= range_d;
      dmx_q   <= dmx_d;
      done_q  <= done_d;
      rdata_q <= rdata_d;
    end
  end

  assign readdata = rdata_q;

  // ---------------------------------------------------------------------
  // Source selection and dividers
  // ---------------------------------------------------------------------

  // Reserved source code falls back to the loop; low or mid oscillator is the loop clock.
  always_comb begin
    src_req   = ctrl1_q[7:6];
    sel_src   = (src_req == clock_source_pkg::SRC_INT || src_req == clock_source_pkg::SRC_EXT) ?
                src_req : clock_source_pkg::SRC_LOOP;
    {loop_rise, loop_fall} = (range_q == clock_source_pkg::RANGE_MID) ?
                             {rise[clock_source_pkg::S_DCO_MID], fall[clock_source_pkg::S_DCO_MID]} :
                             {rise[clock_source_pkg::S_DCO_LOW], fall[clock_source_pkg::S_DCO_LOW]};
    {ext_rise, ext_fall} = ctrl2_q[clock_source_pkg::C2_EOSC] ?
                           {rise[clock_source_pkg::S_OSC], fall[clock_source_pkg::S_OSC]} :
                           {rise[clock_source_pkg::S_EXT_PIN], fall[clock_source_pkg::S_EXT_PIN]};
    case (src_q)
      clock_source_pkg::SRC_INT: begin
        src_rise = rise[clock_source_pkg::S_INT_REF];
        src_fall = fall[clock_source_pkg::S_INT_REF];
      end
      clock_source_pkg::SRC_EXT: begin
        src_rise = ext_rise;
        src_fall = ext_fall;
      end
      default: begin
        src_rise = loop_rise;
        src_fall = loop_fall;
      end
    endcase
    // Reserved high-range codes hold the largest factor.
    reference_divider_select_eff = (ctrl2_q[clock_source_pkg::C2_RANGE] && ctrl1_q[5:3] > clock_source_pkg::HIGH_RANGE_TOP) ?
               clock_source_pkg::HIGH_RANGE_TOP : ctrl1_q[5:3];
    reference_divider_select_exp = {1'b0, reference_divider_select_eff} +
               (ctrl2_q[clock_source_pkg::C2_RANGE] ? clock_source_pkg::HIGH_RANGE_SHIFT : 4'h0);
  end

  // A new source is applied only as the divided clock falls; a wrap frozen by stop is spent after it.
  assign src_d = (out_wrap && !stopped) ? sel_src : src_q;

  assign stopped   = stop_req;
  assign low_power = ctrl2_q[clock_source_pkg::C2_LP];

  // Output divider on the applied source; it is frozen in stop.
  half_period_divider #(.W(LIM_W)) u_out_div (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce && !stopped),
    .rise  (src_rise),
    .fall  (src_fall),
    .limit (ratio_limit({2'b00, ctrl2_q[7:6]})),
    .out   (divided_clock_output),
    .wrap  (out_wrap)
  );

  // Reference divider ahead of the loop.
  half_period_divider #(.W(LIM_W)) u_ref_div (
    .clk   (clk),
    .rstn  (rstn),
    .ce    (ce && len_q),
    .rise  (ext_rise),
    .fall  (ext_fall),
    .limit (ratio_limit(reference_divider_select_exp)),
    .out   (ext_div_out),
    .wrap  ()
  );

  // ---------------------------------------------------------------------
  // Derived clocks, mode and enables
  // ---------------------------------------------------------------------

  // Next state of clocks, mode and loop enables.
  always_comb begin
    bus_d  = (out_wrap && !stopped) ? ~bus_q : bus_q;
    dbg_d  = len_q && (rise[clock_source_pkg::S_DCO_LOW] ? ~dbg_q : dbg_q);
    lref_d = ctrl1_q[clock_source_pkg::C1_LREF] ? lvl[clock_source_pkg::S_INT_REF] : ext_div_out;
    if (stopped) begin
      mode_d = clock_source_pkg::MODE_STOP;
    end else begin
      case (sel_src)
        clock_source_pkg::SRC_INT: mode_d = low_power ? clock_source_pkg::MODE_BYPASS_INT_LP :
                                            clock_source_pkg::MODE_BYPASS_INT;
        clock_source_pkg::SRC_EXT: mode_d = low_power ? clock_source_pkg::MODE_BYPASS_EXT_LP :
                                            clock_source_pkg::MODE_BYPASS_EXT;
        default: mode_d = ctrl1_q[clock_source_pkg::C1_LREF] ? clock_source_pkg::MODE_ENGAGED_INT :
                          clock_source_pkg::MODE_ENGAGED_EXT;
      endcase
    end
    len_d   = !stopped && !(low_power && sel_src != clock_source_pkg::SRC_LOOP);
    iract_d = ctrl1_q[clock_source_pkg::C1_IREN] &&
              (!stopped || ctrl1_q[clock_source_pkg::C1_IRSTOP]);
  end

  // Registers of clocks, mode and enables.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_q   <= clock_source_pkg::SRC_LOOP;
      bus_q   <= 1'b0;
      dbg_q   <= 1'b0;
      lref_q  <= 1'b0;
      mode_q  <= clock_source_pkg::MODE_ENGAGED_INT;
      len_q   <= 1'b1;
      iract_q <= 1'b0;
    end else if (ce) begin
      src_q   <= src_d;
      bus_q   <= bus_d;
      dbg_q   <= dbg_d;
      lref_q  <= lref_d;
      mode_q  <= mode_d;
      len_q   <= len_d;
      iract_q <= iract_d;
    end
  end

  // Outputs toward the loop, oscillator and consumers.
  assign bus_clk                 = bus_q;
  assign debug_clk               = dbg_q;
  assign loop_ref_clk            = lref_q;
  assign loop_enable             = len_q;
  assign int_ref_active          = iract_q;
  assign int_ref_trim            = trim_q;
  assign oscillator_range_select = range_q;
  assign max_freq_32k_option     = dmx_q;
  assign mode                    = mode_q;
  assign osc_ctrl                = {ctrl2_q[clock_source_pkg::C2_RANGE], ctrl2_q[clock_source_pkg::C2_HGO],
                                    ctrl2_q[clock_source_pkg::C2_EOSC], ctrl2_q[clock_source_pkg::C2_EREN],
                                    ctrl2_q[clock_source_pkg::C2_ERSTOP]};

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------

  AST_BUS_HALF: assert property (@(posedge clk) disable iff (!rstn)
    $changed(bus_q) |-> $past(out_wrap))
    else $error("bus clock toggled without a divided clock period");
  AST_DEBUG_HALF: assert property (@(posedge clk) disable iff (!rstn)
    $rose(dbg_q) |-> $past(rise[clock_source_pkg::S_DCO_LOW]) && $past(len_q))
    else $error("debug clock rose without a low oscillator edge");
  AST_RANGE_KEEP: assert property (@(posedge clk) disable iff (!rstn)
    ce && wr_ok && address == clock_source_pkg::OFS_STATUS && byteenable[0] && writedata[7]
    |=> range_q == $past(range_q))
    else $error("unsupported oscillator range was accepted");
  AST_TRIM_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    ce && wr_ok && address == clock_source_pkg::OFS_TRIM && byteenable[1:0] == 2'h3
    |=> int_ref_trim == $past(writedata[8:0]))
    else $error("trim write not applied");
  AST_RESERVED_SRC: assert property (@(posedge clk) disable iff (!rstn)
    ce && !stopped && ctrl1_q[7:6] == 2'h3 && ctrl1_q[clock_source_pkg::C1_LREF]
    |=> mode_q == clock_source_pkg::MODE_ENGAGED_INT)
    else $error("reserved source code did not act as the loop");
  AST_LOOP_REF: assert property (@(posedge clk) disable iff (!rstn)
    ce && ctrl1_q[clock_source_pkg::C1_LREF] |=> lref_q == $past(lvl[clock_source_pkg::S_INT_REF]))
    else $error("loop reference is not the internal reference");
  AST_STOP_MODE: assert property (@(posedge clk) disable iff (!rstn)
    ce && stopped |=> mode_q == clock_source_pkg::MODE_STOP && !len_q)
    else $error("stop did not disable the loop");
  AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (!rstn)
    req && !done_q && ce ##1 ce |-> !waitrequest)
    else $error("bus access not answered after one wait cycle");
  AST_SRC_SWITCH: assert property (@(posedge clk) disable iff (!rstn)
    $changed(src_q) |-> $past(out_wrap))
    else $error("source switched outside a divided clock period end");

endmodule

// ---- rtl/clock_source_pkg.sv ----
// Shared constants, types and register layout of the clock source block.
// Assumes a single 40 MHz system clock and a 32-bit Avalon-MM register bus.
package clock_source_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL1  = 5'h00;
  localparam logic [4:0] OFS_CTRL2  = 5'h04;
  localparam logic [4:0] OFS_TRIM   = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0c;
  localparam logic [4:0] OFS_MODE   = 5'h10;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int C1_SRC_LSB  = 6;  // Clock source select, two bits.
  localparam int C1_REFERENCE_DIVIDER_SELECT_LSB = 3;  // Reference divider select, three bits.
  localparam int C1_LREF     = 2;  // Loop reference select.
  localparam int C1_IREN     = 1;  // Internal reference enable.
  localparam int C1_IRSTOP   = 0;  // Internal reference stop enable.
  localparam int C2_ODIV_LSB = 6;  // Output divider select, two bits.
  localparam int C2_RANGE    = 5;  // Oscillator frequency range.
  localparam int C2_HGO      = 4;  // Oscillator high gain.
  localparam int C2_LP       = 3;  // Low power in bypass modes.
  localparam int C2_EOSC     = 2;  // External reference is the oscillator.
  localparam int C2_EREN     = 1;  // External reference enable.
  localparam int C2_ERSTOP   = 0;  // External reference stop enable.
  localparam int ST_RNG_LSB  = 6;  // Oscillator range select and status.
  localparam int ST_DMX      = 5;  // Maximum frequency for 32 kHz option.
  localparam int ST_LREF     = 4;  // Applied loop reference.
  localparam int ST_SRC_LSB  = 2;  // Applied clock source, two bits.
  localparam int ST_OINIT    = 1;  // Oscillator initialised.
  localparam int TRIM_W      = 9;

  // ---------------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------------
  localparam logic [7:0]        CTRL1_RST = 8'h04;
  localparam logic [7:0]        CTRL2_RST = 8'h40;
  localparam logic [TRIM_W-1:0] TRIM_RST  = 9'h100;
  localparam logic [1:0]        RANGE_RST = 2'h0;
  localparam logic [1:0] SRC_LOOP = 2'h0;
  localparam logic [1:0] SRC_INT  = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;
  localparam logic [1:0] RANGE_LOW = 2'h0;
  localparam logic [1:0] RANGE_MID = 2'h1;
  localparam logic [3:0] HIGH_RANGE_SHIFT = 4'h5;  // Factor 32.
  localparam logic [2:0] HIGH_RANGE_TOP   = 3'h5;  // Codes above are reserved.

  // Indices of the synchronised clock and status inputs.
  localparam int SYNC_W     = 6;
  localparam int S_DCO_LOW  = 0;
  localparam int S_DCO_MID  = 1;
  localparam int S_INT_REF  = 2;
  localparam int S_EXT_PIN  = 3;
  localparam int S_OSC      = 4;
  localparam int S_OSC_INIT = 5;

  typedef enum logic [2:0] {
    MODE_ENGAGED_INT, MODE_ENGAGED_EXT, MODE_BYPASS_INT, MODE_BYPASS_INT_LP,
    MODE_BYPASS_EXT, MODE_BYPASS_EXT_LP, MODE_STOP
  } mode_e;

  // Control lines toward the external crystal oscillator.
  typedef struct packed {
    logic range;
    logic high_gain;
    logic osc_select;
    logic ref_enable;
    logic ref_stop_enable;
  } osc_ctrl_s;

endpackage

// ---- rtl/level_sync.sv ----
// Three-flop synchroniser with glitch filter and edge pulses, one lane per bit.
// Assumes its inputs are asynchronous to clk.
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, rise_q, rise_d, fall_q, fall_d;

  // ---------------------------------------------------------------------
  // Filter: a lane changes once the second and third flops agree.
  // ---------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : lvl_q[i];
    end
    rise_d = lvl_d & ~lvl_q;
    fall_d = ~lvl_d & lvl_q;
  end

  // Registers of the chain; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_q  <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else if (ce) begin
      s1_q   <= din;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign level = lvl_q;
  assign rise  = rise_q;
  assign fall  = fall_q;

endmodule

// ---- rtl/half_period_divider.sv ----
// Divides a sampled clock by counting its half periods.
// Assumes rise and fall are single-cycle pulses on clk.
`timescale 1ns/1ps
module half_period_divider #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         rise,
  input  wire logic         fall,
  input  wire logic [W-1:0] limit,
  output logic              out,
  output logic              wrap
);

  logic [W-1:0] cnt_q, cnt_d, lim_q, lim_d;
  logic         out_q, out_d, wrap_q, wrap_d;

  // ---------------------------------------------------------------------
  // Output toggles every limit+1 half periods; a new limit is taken only
  // as the output falls, so no period is ever cut short.
  // ---------------------------------------------------------------------
  always_comb begin
    cnt_d  = cnt_q;
    out_d  = out_q;
    lim_d  = lim_q;
    wrap_d = 1'b0;
    if (rise || fall) begin
      if (cnt_q >= lim_q) begin
        cnt_d = '0;
        out_d = ~out_q;
        if (out_q) begin
          lim_d  = limit;
          wrap_d = 1'b1;
        end
      end else begin
        cnt_d = W'(cnt_q + 1'b1);
      end
    end
  end

  // Divider state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      lim_q  <= '0;
      out_q  <= 1'b0;
      wrap_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      lim_q  <= lim_d;
      out_q  <= out_d;
      wrap_q <= wrap_d;
    end
  end

  assign out  = out_q;
  assign wrap = wrap_q;

  AST_LIMIT_AT_FALL: assert property (@(posedge clk) disable iff (!rstn)
    $changed(lim_q) |-> $past(out_q) && !out_q)
    else $error("divider limit changed outside a falling output");

endmodule

// ---- verif/osc_model.sv ----
// Slow oscillator and reference clocks around the clock source block.
// Assumes clk is the 40 MHz system clock.
`timescale 1ns/1ps
module osc_model (
  input  wire logic clk,
  input  wire logic rstn,
  output logic      dco_low_clk,
  output logic      dco_mid_clk,
  output logic      int_ref_clk,
  output logic      ext_clk_pin,
  output logic      osc_clock_in,
  output logic      osc_init
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  // Free-running count that every slow clock is taken from.
  always_comb cnt_d = cnt_q + 8'h01;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_q <= 8'h00;
    else cnt_q <= cnt_d;
  end
  // Periods in clk cycles are 64, 32, 128, 256 and 32.
  assign dco_low_clk  = cnt_q[5];
  assign dco_mid_clk  = cnt_q[4];
  assign int_ref_clk  = cnt_q[6];
  assign ext_clk_pin  = cnt_q[7];
  assign osc_clock_in = cnt_q[4];
  assign osc_init     = 1'b1;
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench of the clock source block.
// Assumes osc_model drives the slow clocks; ce stays high, stop is driven by the bench.
`timescale 1ns/1ps
module tb_top;
  logic                        clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, stop_req = 1'b0;
  logic [4:0]                  address = 5'h00;
  logic [31:0]                 writedata = 32'h0, readdata, q;
  logic                        waitrequest, dco_low_clk, dco_mid_clk, int_ref_clk, ext_clk_pin, osc_clock_in;
  logic                        osc_init, divided_clock_output, bus_clk, debug_clk, loop_ref_clk, loop_enable;
  logic                        int_ref_active, max_freq_32k_option;
  logic [8:0]                  int_ref_trim;
  logic [1:0]                  oscillator_range_select;
  clock_source_pkg::osc_ctrl_s osc_ctrl;
  clock_source_pkg::mode_e     mode;
  int                          fail_count = 0, cmp_count = 0, n;
  // Clock of 25 ns.
  always #12.5 clk = ~clk;
  osc_model i_osc (.clk, .rstn, .dco_low_clk, .dco_mid_clk, .int_ref_clk, .ext_clk_pin, .osc_clock_in, .osc_init);
  internal_clock_source i_dut (.clk, .rstn, .ce(1'b1), .address, .read, .write, .writedata, .byteenable(4'hf),
    .readdata, .waitrequest, .dco_low_clk, .dco_mid_clk, .int_ref_clk, .ext_clk_pin, .osc_clock_in, .osc_init,
    .stop_req, .divided_clock_output, .bus_clk, .debug_clk, .loop_ref_clk, .loop_enable, .int_ref_active,
    .int_ref_trim, .oscillator_range_select, .max_freq_32k_option, .osc_ctrl, .mode);
  // One bus access; it ends at the edge where waitrequest is seen low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d = 32'h0);
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    // Waitrequest is sampled at each rising edge; only the watchdog ends a hang.
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Period in clk cycles of divided, bus, debug or loop reference clock.
  task automatic measure(input int sel);
    logic p, v;
    p = 1'b1;
    n = 0;
    for (int k = 0; k < 5000; k++) begin
      @(posedge clk);
      v = sel == 0 ? divided_clock_output : sel == 1 ? bus_clk : sel == 2 ? debug_clk : loop_ref_clk;
      if (v === 1'b1 && p === 1'b0 && n > 0) break;
      if (v === 1'b1 && p === 1'b0) n = 1;
      else if (n > 0) n++;
      p = v;
    end
  endtask
  task automatic t_reset;
    bus(0, 5'h00);
    check("ctrl1", q, 32'h04);
    bus(0, 5'h04);
    check("ctrl2", q, 32'h40);
    bus(0, 5'h08);
    check("trim", q, 32'h100);
    bus(0, 5'h14);
    check("unmapped", q, 32'h0);
    check("mode", mode, clock_source_pkg::MODE_ENGAGED_INT);
    measure(2);
    check("debug", n, 128);
  endtask
  task automatic t_divider;
    bus(1, 5'h00, 32'h44);
    for (int r = 0; r < 4; r++) begin
      bus(1, 5'h04, r << 6);
      measure(0);
      measure(0);
      check("div", n, 128 << r);
      measure(1);
      check("busclk", n, 256 << r);
    end
  endtask
  task automatic t_source;
    bus(1, 5'h04, 32'h0);
    bus(1, 5'h00, 32'h88);
    measure(0);
    measure(0);
    check("ext", n, 256);
    measure(3);
    measure(3);
    check("lref", n, 512);
    bus(1, 5'h00, 32'hc4);
    measure(0);
    measure(0);
    bus(0, 5'h0c);
    check("src", q[4:2], 3'h4);
  endtask
  task automatic t_ctrl;
    bus(1, 5'h0c, 32'h60);
    bus(1, 5'h0c, 32'he0);
    bus(1, 5'h04, 32'h37);
    bus(1, 5'h08, 32'h0a5);
    bus(0, 5'h0c);
    check("rng", q[7:5], 3'h3);
    check("rngo", oscillator_range_select, 2'h1);
    check("dmx", max_freq_32k_option, 1'b1);
    check("osc", osc_ctrl, 5'h1f);
    check("trimo", int_ref_trim, 9'h0a5);
  endtask
  // Stop freezes the divided and bus clocks and holds the debug clock low, then low-power bypass turns the loop off.
  task automatic t_stop;
    logic [1:0] b;
    bus(1, 5'h00, 32'h07);
    stop_req <= 1'b1;
    repeat (3) @(posedge clk);
    check("stopmode", mode, clock_source_pkg::MODE_STOP);
    check("stoplen", loop_enable, 1'b0);
    check("stopdbg", debug_clk, 1'b0);
    check("stopiref", int_ref_active, 1'b1);
    b = {bus_clk, divided_clock_output};
    repeat (300) @(posedge clk);
    check("frozen", {bus_clk, divided_clock_output}, b);
    bus(1, 5'h00, 32'h06);
    repeat (2) @(posedge clk);
    check("irefoff", int_ref_active, 1'b0);
    stop_req <= 1'b0;
    repeat (2) @(posedge clk);
    check("runmode", mode, clock_source_pkg::MODE_ENGAGED_INT);
    check("runlen", loop_enable, 1'b1);
    bus(1, 5'h04, 32'h08);
    bus(1, 5'h00, 32'h44);
    bus(0, 5'h10);
    check("lpmode", q, clock_source_pkg::MODE_BYPASS_INT_LP);
    check("lplen", loop_enable, 1'b0);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence after five cycles of reset.
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_divider;
    t_source;
    t_ctrl;
    t_stop;
    finish_test;
  end
  // Watchdog well past the expected run time.
  initial begin
    #2000000;
    fail_count++;
    finish_test;
  end
endmodule
